//--- rtl/crs_map.svh
/*
  Register indices, field positions and reset values of the call/return sequencer.
  Assumes: included by the sequencer and the testbench; definitions only.
*/
`ifndef CRS_MAP_SVH
`define CRS_MAP_SVH

// Register word indices (byte address = index * 4)
`define CRS_R_CMD      5'd0
`define CRS_R_STATUS   5'd1
`define CRS_R_CFG      5'd2
`define CRS_R_IP       5'd3
`define CRS_R_CS       5'd4
`define CRS_R_SS       5'd5
`define CRS_R_FLAGS    5'd6
`define CRS_R_TGT_IP   5'd7
`define CRS_R_TGT_CS   5'd8
`define CRS_R_RET_IMM  5'd9
`define CRS_R_GATE     5'd10
`define CRS_R_GATE_IP  5'd11
`define CRS_R_GATE_CS  5'd12
`define CRS_R_GATE_SS  5'd13
`define CRS_R_GATE_SP  5'd14
`define CRS_R_HOLE     5'd15
`define CRS_R_GPR      5'd16
`define CRS_R_SP       5'd20
`define CRS_NREG       24

// Field positions
`define CRS_ST_BUSY    0
`define CRS_ST_FAULT   1
`define CRS_CFG_S32    0
`define CRS_CFG_CPL    1
`define CRS_GT_VALID   0
`define CRS_GT_DPL     1
`define CRS_GT_LVL     3
`define CRS_GT_CNT     5

// Write masks, reset values and pop-all skip indices
`define CRS_CFG_MASK   32'h0000_0007
`define CRS_GATE_MASK  32'h0000_03FF
`define CRS_IMM_MASK   32'h0000_FFFF
`define CRS_SEL_MASK   32'h0000_FFFF
`define CRS_CFG_RST    32'h0000_0007
`define CRS_SP_IDX     3'd4
`define CRS_SI_IDX     3'd6

`endif

//--- rtl/crs_pkg.sv
/*
  Types of the call/return sequencer: commands, states, micro-steps, stack port.
  Assumes: crs_map.svh on the include path.
*/
package crs_pkg;

  // Commands written to the command register
  typedef enum logic [3:0] {
    OP_NONE             = 4'h0,
    OP_NEAR_CALL        = 4'h1,
    OP_NEAR_RET         = 4'h2,
    OP_FAR_CALL         = 4'h3,
    OP_FAR_RET          = 4'h4,
    OP_PUSH_ALL_GENERAL = 4'h5,
    OP_POP_ALL_GENERAL  = 4'h6,
    OP_PUSH_FLAGS_LOW   = 4'h7,
    OP_PUSH_FLAGS_FULL  = 4'h8,
    OP_POP_FLAGS_LOW    = 4'h9,
    OP_POP_FLAGS_FULL   = 4'hA,
    OP_GATE_CALL        = 4'hB,
    OP_PRIV_RET         = 4'hC
  } crs_op_t;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b001,
    ST_STEP = 3'b010,
    ST_MEM  = 3'b100
  } crs_state_t;

  typedef enum logic [2:0] {
    A_FIN, A_PUSH, A_POP, A_CHK, A_SWITCH, A_COPY, A_SKIP
  } crs_act_t;

  typedef enum logic [3:0] {
    SRC_NONE, SRC_IP, SRC_CS, SRC_SS, SRC_OSP, SRC_GPR, SRC_FLO, SRC_FFULL,
    SRC_TIP, SRC_TCS, SRC_TSP, SRC_TSS
  } crs_src_t;

  typedef struct packed {
    crs_act_t act;
    crs_src_t src;
  } crs_micro_t;

  // Request to stack memory, held until acknowledged
  typedef struct packed {
    logic        req;
    logic        we;
    logic [15:0] sel;
    logic [31:0] addr;
    logic [31:0] wdata;
    logic        dword;
  } crs_stk_req_t;

endpackage : crs_pkg

//--- rtl/crs_call_return_sequencer.sv
/*
  Call/return sequencer: walks call, return, register save/restore and
  gate-call sequences against stack memory, under Avalon-MM control.
  Assumes: stack memory on clk_sys_i answering each request with stk_ack_i;
  software loads operands, then writes a command while the block is idle.
*/
// Function
// - Near call pushes the instruction pointer, then jumps to the target.
// - Near return pops the instruction pointer, releases operand bytes, resumes.
// - Far call pushes code selector then pointer, then loads both targets.
// - Far return pops pointer then selector, releases operand bytes, resumes.
// - Return operand bytes are added to the stack pointer; zero releases nothing.
// - Near call keeps the code selector; far call changes it.
// - Calls push only linkage values, never general registers or flags; the gate call also pushes copied parameters.
// - Push-all order: accumulator, count, data, base, old stack pointer, frame, source, dest.
// - Pop-all reloads in reverse order, skipping the stack pointer and source index values.
// - Short flags push stores low word; full push stores whole flags.
// - Short flags pop loads low word; full pop loads whole flags.
// - Four privilege levels 0..3; larger number means less privilege.
// - Reaching more privileged code without gate or rights raises protection fault.
// - Gate supplies rights, code selector, entry offset and new stack selector.
// - Gate call: push linkage, check, switch stack, copy old stack, copy parameters.
// - Then copy caller selector and pointer, load entry, begin execution.
// - Parameter copy count comes from the gate count field.
// - Privileged return: pop linkage and stack, check, release, resume.
// - Push decrements then writes; pop reads then increments.
// - Stack steps by 2 or 4 bytes; short values zero-extended on wide stack.
`timescale 1ns/1ps
`include "crs_map.svh"

module crs_call_return_sequencer #(
  parameter int unsigned MAX_PARAMS = 31
) (
  input  wire logic                  clk_sys_i,          // Core clock, 10 MHz
  input  wire logic                  rst_n_i,            // Synchronous reset, active low
  input  wire logic [6:0]            avs_address_i,      // Byte address
  input  wire logic                  avs_read_i,         // Read request
  input  wire logic                  avs_write_i,        // Write request
  input  wire logic [31:0]           avs_writedata_i,    // Write data
  input  wire logic [3:0]            avs_byteenable_i,   // Byte lanes
  output logic [31:0]                avs_readdata_o,     // Read data
  output logic                       avs_waitrequest_o,  // Stall
  output logic [1:0]                 avs_response_o,     // OKAY or SLVERR
  output crs_pkg::crs_stk_req_t      stk_o,              // Stack memory request
  input  wire logic [31:0]           stk_rdata_i,        // Stack read data
  input  wire logic                  stk_ack_i,          // Stack request done
  output logic                       protection_fault_o  // Fault pulse
);
  import crs_pkg::*;

  //--------------------------------------------------------------
  // Elaboration checks and storage
  //--------------------------------------------------------------
  generate
    if (MAX_PARAMS < 1 || MAX_PARAMS > 31) begin : g_bad_param
      $error("MAX_PARAMS must be 1..31");
    end
  endgenerate

  logic [31:0]  rf_q [0:`CRS_NREG-1];
  crs_state_t   st_q;
  crs_op_t      op_q;
  logic [3:0]   step_q;
  logic [4:0]   cp_q;
  logic         cp_rd_q;
  logic [31:0]  wsp_q;
  logic [15:0]  wss_q;
  logic [31:0]  tip_q, tcs_q, tsp_q, tss_q, tmp_q;
  crs_stk_req_t stk_q;
  logic         fault_q, fault_pls_q, resp_q;
  logic [31:0]  rdata_q;
  logic [1:0]   rsp_q;

  //--------------------------------------------------------------
  // Helpers
  //--------------------------------------------------------------
  // A 16-bit stack wraps inside the low half and keeps the upper half
  function automatic logic [31:0] sp_add(input logic [31:0] sp, input logic [31:0] d,
                                         input logic w32);
    sp_add = w32 ? sp + d : {sp[31:16], sp[15:0] + d[15:0]};
  endfunction : sp_add

  function automatic logic [31:0] be_merge(input logic [31:0] o, input logic [31:0] n,
                                           input logic [3:0] be);
    for (int i = 0; i < 4; i++) begin
      be_merge[8*i +: 8] = be[i] ? n[8*i +: 8] : o[8*i +: 8];
    end
  endfunction : be_merge

  function automatic logic [31:0] wr_mask(input logic [4:0] i);
    case (i)
      `CRS_R_CFG:     wr_mask = `CRS_CFG_MASK;
      `CRS_R_GATE:    wr_mask = `CRS_GATE_MASK;
      `CRS_R_RET_IMM: wr_mask = `CRS_IMM_MASK;
      `CRS_R_CS, `CRS_R_SS, `CRS_R_TGT_CS, `CRS_R_GATE_CS, `CRS_R_GATE_SS:
        wr_mask = `CRS_SEL_MASK;
      default:        wr_mask = 32'hFFFF_FFFF;
    endcase
  endfunction : wr_mask

  // Micro-step table: only linkage values are listed for calls, plus the parameter copy step of the gate call
  function automatic crs_micro_t micro(input crs_op_t op, input logic [3:0] s);
    micro = '{A_FIN, SRC_NONE};
    case (op)
      OP_NEAR_CALL:        if (s == 4'd0) micro = '{A_PUSH, SRC_IP};
      OP_NEAR_RET:         if (s == 4'd0) micro = '{A_POP, SRC_TIP};
      OP_FAR_CALL: begin
        case (s)
          4'd0:    micro = '{A_CHK, SRC_NONE};
          4'd1:    micro = '{A_PUSH, SRC_CS};
          4'd2:    micro = '{A_PUSH, SRC_IP};
          default: micro = '{A_FIN, SRC_NONE};
        endcase
      end
      OP_FAR_RET: begin
        case (s)
          4'd0:    micro = '{A_POP, SRC_TIP};
          4'd1:    micro = '{A_POP, SRC_TCS};
          4'd2:    micro = '{A_CHK, SRC_NONE};
          default: micro = '{A_FIN, SRC_NONE};
        endcase
      end
      OP_PUSH_ALL_GENERAL: if (s < 4'd8) micro = '{A_PUSH, SRC_GPR};
      OP_POP_ALL_GENERAL:  if (s < 4'd8) micro = '{A_POP, SRC_GPR};
      OP_PUSH_FLAGS_LOW:   if (s == 4'd0) micro = '{A_PUSH, SRC_FLO};
      OP_PUSH_FLAGS_FULL:  if (s == 4'd0) micro = '{A_PUSH, SRC_FFULL};
      OP_POP_FLAGS_LOW:    if (s == 4'd0) micro = '{A_POP, SRC_FLO};
      OP_POP_FLAGS_FULL:   if (s == 4'd0) micro = '{A_POP, SRC_FFULL};
      OP_GATE_CALL: begin
        case (s)
          4'd0:    micro = '{A_PUSH, SRC_CS};
          4'd1:    micro = '{A_PUSH, SRC_IP};
          4'd2:    micro = '{A_CHK, SRC_NONE};
          4'd3:    micro = '{A_SWITCH, SRC_NONE};
          4'd4:    micro = '{A_PUSH, SRC_SS};
          4'd5:    micro = '{A_PUSH, SRC_OSP};
          4'd6:    micro = '{A_COPY, SRC_NONE};
          4'd7:    micro = '{A_PUSH, SRC_CS};
          4'd8:    micro = '{A_PUSH, SRC_IP};
          default: micro = '{A_FIN, SRC_NONE};
        endcase
      end
      OP_PRIV_RET: begin
        case (s)
          4'd0:    micro = '{A_POP, SRC_TIP};
          4'd1:    micro = '{A_POP, SRC_TCS};
          4'd2:    micro = '{A_SKIP, SRC_NONE};
          4'd3:    micro = '{A_POP, SRC_TSP};
          4'd4:    micro = '{A_POP, SRC_TSS};
          4'd5:    micro = '{A_CHK, SRC_NONE};
          default: micro = '{A_FIN, SRC_NONE};
        endcase
      end
      default:             micro = '{A_FIN, SRC_NONE};
    endcase
  endfunction : micro

  //--------------------------------------------------------------
  // Decoded fields
  //--------------------------------------------------------------
  logic [4:0]  idx;
  logic        mapped, busy, wr_take, start, s32;
  logic [1:0]  cpl, g_dpl, g_lvl;
  logic [4:0]  n_par;
  crs_micro_t  mu;
  logic        dw, chk_ok, chk_fail, fin, pop_done;
  logic [31:0] isz, psp, pv, rtn_sp;
  logic [2:0]  gidx;

  assign idx      = avs_address_i[6:2];
  assign mapped   = (idx < 5'(`CRS_NREG)) && (idx != `CRS_R_HOLE);
  assign busy     = (st_q != ST_IDLE);
  assign wr_take  = avs_write_i && resp_q;
  assign start    = wr_take && !busy && (idx == `CRS_R_CMD) && avs_byteenable_i[0]
                    && (avs_writedata_i[3:0] != 4'h0) && (avs_writedata_i[3:0] <= 4'hC);
  assign s32      = rf_q[`CRS_R_CFG][`CRS_CFG_S32];
  assign cpl      = rf_q[`CRS_R_CFG][`CRS_CFG_CPL +: 2];
  assign g_dpl    = rf_q[`CRS_R_GATE][`CRS_GT_DPL +: 2];
  assign g_lvl    = rf_q[`CRS_R_GATE][`CRS_GT_LVL +: 2];
  // Count clipped to what the copy counter can serve
  assign n_par    = (rf_q[`CRS_R_GATE][`CRS_GT_CNT +: 5] > 5'(MAX_PARAMS)) ?
                    5'(MAX_PARAMS) : rf_q[`CRS_R_GATE][`CRS_GT_CNT +: 5];
  assign mu       = micro(op_q, step_q);
  assign dw       = s32 || (mu.src == SRC_FFULL);
  assign isz      = dw ? 32'd4 : 32'd2;
  assign psp      = sp_add(wsp_q, 32'd0 - isz, s32);
  assign gidx     = (op_q == OP_POP_ALL_GENERAL) ? 3'd7 - step_q[2:0] : step_q[2:0];
  assign fin      = (st_q == ST_STEP) && (mu.act == A_FIN);
  assign pop_done = (st_q == ST_MEM) && stk_ack_i && !stk_q.we && (mu.act == A_POP);

  // Privilege checks; larger level number is less privileged
  always_comb begin
    case (op_q)
      OP_FAR_CALL:  chk_ok = rf_q[`CRS_R_TGT_CS][1:0] >= cpl;
      OP_FAR_RET:   chk_ok = tcs_q[1:0] >= cpl;
      OP_GATE_CALL: chk_ok = rf_q[`CRS_R_GATE][`CRS_GT_VALID]
                             && (cpl <= g_dpl) && (g_lvl < cpl);
      OP_PRIV_RET:  chk_ok = tcs_q[1:0] > cpl;
      default:      chk_ok = 1'b1;
    endcase
  end
  assign chk_fail = (st_q == ST_STEP) && (mu.act == A_CHK) && !chk_ok;

  // Push data; short values land zero-extended on a wide stack
  always_comb begin
    case (mu.src)
      SRC_IP:    pv = rf_q[`CRS_R_IP];
      SRC_CS:    pv = rf_q[`CRS_R_CS];
      SRC_SS:    pv = rf_q[`CRS_R_SS];
      SRC_OSP:   pv = rf_q[`CRS_R_SP];
      SRC_GPR:   pv = rf_q[5'(`CRS_R_GPR + {2'b00, gidx})];
      SRC_FLO:   pv = {16'h0000, rf_q[`CRS_R_FLAGS][15:0]};
      SRC_FFULL: pv = rf_q[`CRS_R_FLAGS];
      default:   pv = tmp_q;
    endcase
  end

  // Release applied last, on whichever stack is then current
  assign rtn_sp = sp_add((op_q == OP_PRIV_RET) ? tsp_q : wsp_q,
                         rf_q[`CRS_R_RET_IMM] & `CRS_IMM_MASK, s32);

  //--------------------------------------------------------------
  // Sequencer
  //--------------------------------------------------------------
  // Working pointer and selector keep the committed ones untouched until the end
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      st_q    <= ST_IDLE;
      op_q    <= OP_NONE;
      step_q  <= 4'h0;
      cp_q    <= 5'h00;
      cp_rd_q <= 1'b1;
      wsp_q   <= 32'h0000_0000;
      wss_q   <= 16'h0000;
      stk_q   <= '0;
    end else begin
      case (st_q)
        ST_IDLE: begin
          if (start) begin
            op_q    <= crs_op_t'(avs_writedata_i[3:0]);
            step_q  <= 4'h0;
            cp_q    <= 5'h00;
            cp_rd_q <= 1'b1;
            wsp_q   <= rf_q[`CRS_R_SP];
            wss_q   <= rf_q[`CRS_R_SS][15:0];
            st_q    <= ST_STEP;
          end
        end
        ST_STEP: begin
          case (mu.act)
            A_PUSH: begin
              // A 2-byte item carries nothing above its low half
              stk_q <= '{1'b1, 1'b1, wss_q, psp, dw ? pv : {16'h0000, pv[15:0]}, dw};
              wsp_q <= psp;
              st_q  <= ST_MEM;
            end
            A_POP: begin
              stk_q <= '{1'b1, 1'b0, wss_q, wsp_q, 32'h0000_0000, dw};
              wsp_q <= sp_add(wsp_q, isz, s32);
              st_q  <= ST_MEM;
            end
            A_CHK: begin
              if (chk_ok) begin
                step_q <= step_q + 4'h1;
              end else begin
                st_q <= ST_IDLE;
              end
            end
            A_SWITCH: begin
              wsp_q  <= rf_q[`CRS_R_GATE_SP];
              wss_q  <= rf_q[`CRS_R_GATE_SS][15:0];
              step_q <= step_q + 4'h1;
            end
            A_SKIP: begin
              wsp_q  <= sp_add(wsp_q, {27'h0, n_par} * isz, s32);
              step_q <= step_q + 4'h1;
            end
            A_COPY: begin
              if (cp_q == n_par) begin
                step_q <= step_q + 4'h1;
              end else if (cp_rd_q) begin
                // Deepest parameter first keeps the caller's order on the new stack
                stk_q <= '{1'b1, 1'b0, rf_q[`CRS_R_SS][15:0],
                           sp_add(rf_q[`CRS_R_SP], {27'h0, 5'(n_par - cp_q - 5'h01)} * isz, s32),
                           32'h0000_0000, s32};
                st_q  <= ST_MEM;
              end else begin
                stk_q <= '{1'b1, 1'b1, wss_q, psp, s32 ? tmp_q : {16'h0000, tmp_q[15:0]}, s32};
                wsp_q <= psp;
                st_q  <= ST_MEM;
              end
            end
            default: st_q <= ST_IDLE;
          endcase
        end
        ST_MEM: begin
          if (stk_ack_i) begin
            stk_q.req <= 1'b0;
            st_q      <= ST_STEP;
            if (mu.act == A_COPY) begin
              cp_rd_q <= !cp_rd_q;
              if (!cp_rd_q) begin
                cp_q <= cp_q + 5'h01;
              end
            end else begin
              step_q <= step_q + 4'h1;
            end
          end
        end
        default: st_q <= ST_IDLE;
      endcase
    end
  end

  // Popped linkage and copied parameter held aside until commit
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      tip_q <= 32'h0000_0000;
      tcs_q <= 32'h0000_0000;
      tsp_q <= 32'h0000_0000;
      tss_q <= 32'h0000_0000;
      tmp_q <= 32'h0000_0000;
    end else begin
      if (pop_done && mu.src == SRC_TIP) tip_q <= stk_rdata_i;
      if (pop_done && mu.src == SRC_TCS) tcs_q <= stk_rdata_i & `CRS_SEL_MASK;
      if (pop_done && mu.src == SRC_TSP) tsp_q <= stk_rdata_i;
      if (pop_done && mu.src == SRC_TSS) tss_q <= stk_rdata_i & `CRS_SEL_MASK;
      if (st_q == ST_MEM && stk_ack_i && mu.act == A_COPY && cp_rd_q) tmp_q <= stk_rdata_i;
    end
  end

  //--------------------------------------------------------------
  // Register file: bus writes, pops and commit
  //--------------------------------------------------------------
  // Bus writes are ignored while busy so operands cannot shift mid-sequence
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      for (int i = 0; i < `CRS_NREG; i++) begin
        rf_q[i] <= 32'h0000_0000;
      end
      rf_q[`CRS_R_CFG] <= `CRS_CFG_RST;
    end else begin
      if (wr_take && !busy && mapped && idx != `CRS_R_STATUS) begin
        rf_q[idx] <= be_merge(rf_q[idx], avs_writedata_i, avs_byteenable_i) & wr_mask(idx);
      end
      if (pop_done && mu.src == SRC_GPR && gidx != `CRS_SI_IDX && gidx != `CRS_SP_IDX) begin
        rf_q[5'(`CRS_R_GPR + {2'b00, gidx})] <= stk_rdata_i;
      end
      if (pop_done && mu.src == SRC_FLO) begin
        rf_q[`CRS_R_FLAGS][15:0] <= stk_rdata_i[15:0];
      end
      if (pop_done && mu.src == SRC_FFULL) begin
        rf_q[`CRS_R_FLAGS] <= stk_rdata_i;
      end
      if (fin) begin
        case (op_q)
          OP_NEAR_CALL: begin
            rf_q[`CRS_R_IP] <= rf_q[`CRS_R_TGT_IP];
            rf_q[`CRS_R_SP] <= wsp_q;
          end
          OP_FAR_CALL: begin
            rf_q[`CRS_R_CS] <= rf_q[`CRS_R_TGT_CS];
            rf_q[`CRS_R_IP] <= rf_q[`CRS_R_TGT_IP];
            rf_q[`CRS_R_SP] <= wsp_q;
          end
          OP_NEAR_RET: begin
            rf_q[`CRS_R_IP] <= tip_q;
            rf_q[`CRS_R_SP] <= rtn_sp;
          end
          OP_FAR_RET: begin
            rf_q[`CRS_R_IP] <= tip_q;
            rf_q[`CRS_R_CS] <= tcs_q;
            rf_q[`CRS_R_SP] <= rtn_sp;
          end
          OP_GATE_CALL: begin
            rf_q[`CRS_R_IP] <= rf_q[`CRS_R_GATE_IP];
            rf_q[`CRS_R_CS] <= rf_q[`CRS_R_GATE_CS];
            rf_q[`CRS_R_SS] <= rf_q[`CRS_R_GATE_SS];
            rf_q[`CRS_R_SP] <= wsp_q;
            rf_q[`CRS_R_CFG][`CRS_CFG_CPL +: 2] <= g_lvl;
          end
          OP_PRIV_RET: begin
            rf_q[`CRS_R_IP] <= tip_q;
            rf_q[`CRS_R_CS] <= tcs_q;
            rf_q[`CRS_R_SS] <= tss_q;
            rf_q[`CRS_R_SP] <= rtn_sp;
            rf_q[`CRS_R_CFG][`CRS_CFG_CPL +: 2] <= tcs_q[1:0];
          end
          default: rf_q[`CRS_R_SP] <= wsp_q;
        endcase
      end
      if (start) begin
        rf_q[`CRS_R_CMD] <= {28'h0, avs_writedata_i[3:0]};
      end
    end
  end

  //--------------------------------------------------------------
  // Fault flag and pulse
  //--------------------------------------------------------------
  // A new fault wins over a clear in the same cycle
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      fault_q     <= 1'b0;
      fault_pls_q <= 1'b0;
    end else begin
      fault_pls_q <= chk_fail;
      fault_q     <= chk_fail || (fault_q && !(wr_take && idx == `CRS_R_STATUS
                     && avs_byteenable_i[0] && avs_writedata_i[`CRS_ST_FAULT]));
    end
  end

  //--------------------------------------------------------------
  // Avalon-MM slave: one wait cycle per access
  //--------------------------------------------------------------
  always_ff @(posedge clk_sys_i) begin
    if (!rst_n_i) begin
      resp_q  <= 1'b0;
      rdata_q <= 32'h0000_0000;
      rsp_q   <= 2'b00;
    end else begin
      resp_q <= (avs_read_i || avs_write_i) && !resp_q;
      if ((avs_read_i || avs_write_i) && !resp_q) begin
        rsp_q <= mapped ? 2'b00 : 2'b10;
        if (!mapped || !avs_read_i) begin
          rdata_q <= 32'h0000_0000;
        end else if (idx == `CRS_R_STATUS) begin
          rdata_q <= {30'h0, fault_q, busy};
        end else begin
          rdata_q <= rf_q[idx];
        end
      end
    end
  end

  assign avs_waitrequest_o  = (avs_read_i || avs_write_i) && !resp_q;
  assign avs_readdata_o     = rdata_q;
  assign avs_response_o     = rsp_q;
  assign stk_o              = stk_q;
  assign protection_fault_o = fault_pls_q;

endmodule : crs_call_return_sequencer

//--- tb/crs_seq_sva.sv
/* Checker on the sequencer's bus and stack ports.
   Assumes: bound to every crs_call_return_sequencer. */
`timescale 1ns/1ps
module crs_seq_sva import crs_pkg::*; (
  input wire logic            clk_sys_i,          // Clock
  input wire logic            rst_n_i,            // Reset
  input wire logic [6:0]      avs_address_i,      // Address
  input wire logic            avs_read_i,         // Read
  input wire logic            avs_write_i,        // Write
  input wire logic [31:0]     avs_writedata_i,    // Write data
  input wire logic [3:0]      avs_byteenable_i,   // Lanes
  input wire logic [31:0]     avs_readdata_o,     // Read data
  input wire logic            avs_waitrequest_o,  // Stall
  input wire logic [1:0]      avs_response_o,     // Response
  input crs_pkg::crs_stk_req_t stk_o,             // Stack request
  input wire logic [31:0]     stk_rdata_i,        // Stack data
  input wire logic            stk_ack_i,          // Stack done
  input wire logic            protection_fault_o  // Fault
);
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (!rst_n_i);
  // Access in flight and answered this cycle
  wire logic acc_w = avs_read_i | avs_write_i;
  wire logic done_w = acc_w & ~avs_waitrequest_o;
  a_wait_one: assert property ($rose(acc_w) |-> avs_waitrequest_o ##1 !avs_waitrequest_o) else $error("late answer");
  a_idle_nostall: assert property (!acc_w |-> !avs_waitrequest_o) else $error("stall while idle");
  a_unmap_err: assert property (done_w && avs_address_i[6:2] == 5'h0F |-> avs_response_o == 2'h2
    && (avs_write_i || avs_readdata_o == 32'h0)) else $error("hole not refused");
  a_map_ok: assert property (done_w && avs_address_i[6:2] < 5'h0F |-> avs_response_o == 2'h0) else $error("bad error");
  a_stk_hold: assert property (stk_o.req && !stk_ack_i |=> stk_o.req && $stable(stk_o)) else $error("req moved");
  a_stk_drop: assert property (stk_o.req && stk_ack_i |=> !stk_o.req) else $error("req kept");
  a_fault_pulse: assert property (protection_fault_o |=> !protection_fault_o) else $error("long fault");
  a_short_zext: assert property (stk_o.req && stk_o.we && !stk_o.dword |-> stk_o.wdata[31:16] == 16'h0)
    else $error("short item not padded");
  cover property (protection_fault_o);
  cover property (stk_o.req && stk_o.we && stk_ack_i);
  cover property (stk_o.req && !stk_o.we && stk_ack_i);
endmodule : crs_seq_sva
bind crs_call_return_sequencer crs_seq_sva u_crs_seq_sva (.*);

//--- tb/crs_stack_model.sv
/* Stack memory answering the sequencer after 0..2 idle cycles.
   Assumes: stack lies in the first kilobyte of the offset space. */
`timescale 1ns/1ps
module crs_stack_model import crs_pkg::*; (
  input wire logic             clk_i,   // Clock
  input crs_pkg::crs_stk_req_t stk_i,   // Request
  output logic [31:0]          rdata_o, // Read data
  output logic                 ack_o    // Done pulse
);
  logic [31:0] mem [256];
  logic [1:0]  dly_q = 2'h0;
  initial rdata_o = 32'h0;
  initial ack_o = 1'b0;
  // Data toggles when idle so stale values never look valid
  always @(posedge clk_i) begin
    ack_o <= 1'b0;
    rdata_o <= ~rdata_o;
    if (stk_i.req && !ack_o) begin
      if (dly_q == 2'h0) begin
        ack_o <= 1'b1;
        dly_q <= 2'($urandom % 3);
        if (stk_i.we) mem[stk_i.addr[9:2]] <= stk_i.wdata;
        else rdata_o <= mem[stk_i.addr[9:2]];
      end else dly_q <= dly_q - 2'h1;
    end
  end
endmodule : crs_stack_model

//--- tb/tb_top.sv
/* Self-checking bench of the call/return sequencer.
   Assumes: crs_map.svh on the include path; 32-bit stack at level 3. */
`timescale 1ns/1ps
`include "crs_map.svh"
module tb_top;
  import crs_pkg::*;
  logic clk_sys_i = 0, rst_n_i = 0, rd = 0, wr = 0, ack, flt, wt;
  logic [6:0] adr = 0;
  logic [31:0] wd = 0, q, rdat, ip, sp, cs, g [8];
  logic [1:0] rsp;
  crs_stk_req_t stk;
  int n_errors = 0, n_compared = 0, cyc = 0;
  always #50 clk_sys_i = ~clk_sys_i;
  crs_call_return_sequencer u_crs_call_return_sequencer (.clk_sys_i(clk_sys_i), .rst_n_i(rst_n_i),
    .avs_address_i(adr), .avs_read_i(rd), .avs_write_i(wr), .avs_writedata_i(wd), .avs_byteenable_i(4'hF),
    .avs_readdata_o(q), .avs_waitrequest_o(wt), .avs_response_o(rsp), .stk_o(stk), .stk_rdata_i(rdat),
    .stk_ack_i(ack), .protection_fault_o(flt));
  crs_stack_model u_crs_stack_model (.clk_i(clk_sys_i), .stk_i(stk), .rdata_o(rdat), .ack_o(ack));
  task automatic give_verdict;
    if (n_errors == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : give_verdict
  // Hang guard
  always @(posedge clk_sys_i) if (++cyc == 20000) begin n_errors++; give_verdict(); end
  task automatic chk(input string nm, input logic [31:0] s, input logic [31:0] e);
    n_compared++;
    if (s !== e) begin n_errors++; $display("MISMATCH %s exp %h seen %h", nm, e, s); end
  endtask : chk
  // Bus cycle; request held until waitrequest is seen low at a rising edge
  task automatic acc(input logic w, input logic [4:0] i, input logic [31:0] d, output logic [31:0] r);
    adr <= {i, 2'b00}; wd <= d; wr <= w; rd <= !w;
    do @(posedge clk_sys_i); while (wt !== 1'b0);
    r = q;
    wr <= 1'b0; rd <= 1'b0;
    @(posedge clk_sys_i);
  endtask : acc
  task automatic wrr(input logic [4:0] i, input logic [31:0] d); logic [31:0] r; acc(1, i, d, r); endtask : wrr
  task automatic rdc(input string nm, input logic [4:0] i, input logic [31:0] e);
    logic [31:0] r; acc(0, i, 0, r); chk(nm, r, e);
  endtask : rdc
  task automatic run(input crs_op_t op);
    logic [31:0] r;
    wrr(`CRS_R_CMD, 32'(op));
    do acc(0, `CRS_R_STATUS, 0, r); while (r[0] !== 1'b0);
  endtask : run
  function automatic logic [31:0] m(input logic [31:0] a); return u_crs_stack_model.mem[a[9:2]]; endfunction
  initial begin
    void'($urandom(32'h44cc));
    repeat (8) @(posedge clk_sys_i);
    rst_n_i <= 1'b1;
    @(posedge clk_sys_i);
    rdc("cfg", `CRS_R_CFG, 32'h7);
    rdc("hole", `CRS_R_HOLE, 32'h0);
    ip = $urandom; sp = 32'h200; cs = {16'h0, 14'($urandom), 2'h3};
    wrr(`CRS_R_IP, ip); wrr(`CRS_R_SP, sp); wrr(`CRS_R_CS, cs); wrr(`CRS_R_TGT_IP, 32'h1234);
    run(OP_NEAR_CALL);
    rdc("nc ip", `CRS_R_IP, 32'h1234);
    rdc("nc sp", `CRS_R_SP, sp - 4);
    chk("nc mem", m(sp - 4), ip);
    rdc("nc cs", `CRS_R_CS, cs);
    wrr(`CRS_R_RET_IMM, 32'h8);
    run(OP_NEAR_RET);
    rdc("nr ip", `CRS_R_IP, ip);
    rdc("nr sp", `CRS_R_SP, sp + 8);
    wrr(`CRS_R_SP, sp); wrr(`CRS_R_RET_IMM, 0); wrr(`CRS_R_TGT_CS, 32'hABC7);
    run(OP_FAR_CALL);
    chk("fc cs", m(sp - 4), cs);
    chk("fc ip", m(sp - 8), ip);
    rdc("fc tcs", `CRS_R_CS, 32'hABC7);
    run(OP_FAR_RET);
    rdc("fr cs", `CRS_R_CS, cs);
    rdc("fr sp", `CRS_R_SP, sp);
    for (int k = 0; k < 8; k++) begin
      g[k] = (k == 4) ? sp : $urandom;
      wrr(5'(`CRS_R_GPR + k), g[k]);
    end
    run(OP_PUSH_ALL_GENERAL);
    for (int k = 0; k < 8; k++) chk("pa", m(sp - 4 * (k + 1)), g[k]);
    wrr(`CRS_R_GPR, 0);
    run(OP_POP_ALL_GENERAL);
    rdc("pp acc", `CRS_R_GPR, g[0]);
    wrr(`CRS_R_FLAGS, g[1]);
    run(OP_PUSH_FLAGS_LOW);
    chk("pfl", m(sp - 4), {16'h0, g[1][15:0]});
    run(OP_PUSH_FLAGS_FULL);
    chk("pff", m(sp - 8), g[1]);
    wrr(`CRS_R_FLAGS, 0);
    run(OP_POP_FLAGS_FULL);
    rdc("ppf", `CRS_R_FLAGS, g[1]);
    wrr(`CRS_R_GATE, 0);
    run(OP_GATE_CALL);
    rdc("gc st", `CRS_R_STATUS, 32'h2);
    rdc("gc sp", `CRS_R_SP, sp - 4);
    wrr(`CRS_R_GATE, 32'h27); wrr(`CRS_R_GATE_IP, 32'h5678);
    wrr(`CRS_R_GATE_SS, 32'h20); wrr(`CRS_R_GATE_SP, 32'h300);
    run(OP_GATE_CALL);
    rdc("gk ip", `CRS_R_IP, 32'h5678);
    rdc("gk sp", `CRS_R_SP, 32'h2EC);
    rdc("gk cfg", `CRS_R_CFG, 32'h1);
    chk("gk osp", m(32'h2F8), sp - 4);
    chk("gk par", m(32'h2F4), {16'h0, g[1][15:0]});
    chk("gk lnk", m(32'h2EC), ip);
    rdc("gk cnt", 5'(`CRS_R_GPR + 1), g[1]);
    wrr(`CRS_R_RET_IMM, 32'h4);
    run(OP_PRIV_RET);
    rdc("pr ip", `CRS_R_IP, ip);
    rdc("pr sp", `CRS_R_SP, sp);
    rdc("pr cfg", `CRS_R_CFG, 32'h7);
    give_verdict();
  end
endmodule : tb_top
